/* shared/adceic_defines.vh */
// register map, field positions and reset values of the event/irq block
// Notes on behaviour
// - input codes 0x19, 0x1A, 0x1B pick bandgap, quarter core, quarter pad.
// - event control bit 5 gates a pulse out on each window match.
// - event control bit 4 gates a pulse out on each new result.
// - event control bit 1: flush event flushes, then starts a conversion.
// - event control bit 0: start event starts a conversion.
// - ones written to enable-clear drop those enables and their requests.
// - ones written to enable-set raise those enables; zeros do nothing.
// - enable-set and enable-clear both read back the current enables.
// - interrupt is high while any flag is set with its enable set.
// - sync-done flag sets on busy falling, unless setup caused it.
// - window flag sets one clock after the window match.
// - window and result flags clear by write-one or result read.
// - overrun flag sets when a result lands before the last was read.
// - result flag sets when a conversion result arrives.
// - writing one to a flag clears it; zero leaves it alone.
// - sync busy follows a cross-domain register sync start and end.
// - the result read that clears flags is the 16-bit result register.
`ifndef ADCEIC_DEFINES_VH
`define ADCEIC_DEFINES_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ADCEIC_IDX_INCTL    8'h10
`define ADCEIC_IDX_EVCTL    8'h14
`define ADCEIC_IDX_ENCLR    8'h16
`define ADCEIC_IDX_ENSET    8'h17
`define ADCEIC_IDX_FLAGS    8'h18
`define ADCEIC_IDX_STATUS   8'h19
`define ADCEIC_IDX_RESULT   8'h1A

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define ADCEIC_EVCTL_MASK   8'h33
`define ADCEIC_EV_START     0
`define ADCEIC_EV_FLUSH     1
`define ADCEIC_EV_RESOUT    4
`define ADCEIC_EV_WINOUT    5
`define ADCEIC_FL_RES       0
`define ADCEIC_FL_OVR       1
`define ADCEIC_FL_WIN       2
`define ADCEIC_FL_SYNC      3
`define ADCEIC_STATUS_BUSY  7
`define ADCEIC_SEL_BANDGAP  5'h19
`define ADCEIC_SEL_COREQ    5'h1A
`define ADCEIC_SEL_PADQ     5'h1B
`define ADCEIC_READ_CLR     4'h5

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define ADCEIC_RST_8        8'h00
`define ADCEIC_RST_4        4'h0
`define ADCEIC_RST_IN       5'h00
`define ADCEIC_RST_RES      16'h0000
`define ADCEIC_RESP_OKAY    2'h0
`define ADCEIC_RESP_SLVERR  2'h2

`endif

/* core/adceic_flag_bank.v */
// sticky flag bank with set-over-clear priority
`timescale 1ns/1ns
`default_nettype none
module adceic_flag_bank #(
   parameter W = 4
) (
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         clkEn,
   input  wire [W-1:0] setReq,
   input  wire [W-1:0] clrReq,
   output reg  [W-1:0] flags_q
);
   wire [W-1:0] flags_d;

   // ------------------------------------------------------------
   // set wins over a clear in the same cycle
   // ------------------------------------------------------------
   assign flags_d = (flags_q & ~clrReq) | setReq;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flags_q <= {W{1'b0}};
      end else if (clkEn) begin
         flags_q <= flags_d;
      end
   end
endmodule // adceic_flag_bank
`default_nettype wire

/* core/adceic_sync_watch.v */
// watches the converter's sync busy level and reports a finished sync
`timescale 1ns/1ns
`default_nettype none
module adceic_sync_watch (
   input  wire clk_sys,
   input  wire rst,
   input  wire clkEn,
   input  wire domain_sync_pending,
   input  wire syncBySetup,
   output reg  busy_q,
   output reg  done_q
);
   reg  cause_q;
   wire done_d;

   // ------------------------------------------------------------
   // falling busy, unless the sync came from enable or soft reset
   // ------------------------------------------------------------
   assign done_d = busy_q & ~domain_sync_pending & ~(cause_q | syncBySetup);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_q  <= 1'b0;
         cause_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (clkEn) begin
         busy_q  <= domain_sync_pending;
         cause_q <= domain_sync_pending & (cause_q | syncBySetup);
         done_q  <= done_d;
      end
   end
endmodule // adceic_sync_watch
`default_nettype wire

/* core/adceic_top.v */
// converter event and interrupt control with an axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "adceic_defines.vh"
module adceic_top (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        clkEn,
   input  wire [9:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [9:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   input  wire        startEvtIn,
   input  wire        flushEvtIn,
   input  wire        convResultValid,
   input  wire [15:0] convResultData,
   input  wire        windowMatch,
   input  wire        domain_sync_pending,
   input  wire        syncBySetup,
   output reg         startReq_q,
   output reg         flushReq_q,
   output reg         resultEvtOut_q,
   output reg         windowEvtOut_q,
   output reg  [4:0]  positiveInputSelect_q,
   output reg         selBandgap_q,
   output reg         selCoreQuarter_q,
   output reg         selPadQuarter_q,
   output reg         irq_q
);

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function isMapped;
      input [7:0] idx;
      begin
         case (idx)
            `ADCEIC_IDX_INCTL,
            `ADCEIC_IDX_EVCTL,
            `ADCEIC_IDX_ENCLR,
            `ADCEIC_IDX_ENSET,
            `ADCEIC_IDX_FLAGS,
            `ADCEIC_IDX_STATUS,
            `ADCEIC_IDX_RESULT: isMapped = 1'b1;
            default:            isMapped = 1'b0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg         awHeld_q;
   reg  [7:0]  awIdx_q;
   reg         wHeld_q;
   reg  [7:0]  wData_q;
   reg         wLane_q;
   reg  [7:0]  evtCtl_q;
   reg  [4:0]  inSel_d;
   reg  [3:0]  intEn_q;
   reg  [15:0] result_q;
   reg         unread_q;
   reg         flushPend_q;

   reg         awHeld_d;
   reg         wHeld_d;
   reg         bvalid_d;
   reg         rvalid_d;
   reg  [31:0] rdata_d;
   reg  [1:0]  rresp_d;
   reg  [3:0]  intEn_d;
   reg  [7:0]  evtCtl_d;

   wire        awTake;
   wire        wTake;
   wire        wrGo;
   wire        arTake;
   wire [7:0]  arIdx;
   wire        wrHit;
   wire        wrEvt;
   wire        wrInSel;
   wire        wrClr;
   wire        wrSet;
   wire        wrFlags;
   wire        resRead;
   wire [3:0]  flagSet;
   wire [3:0]  flagClr;
   wire [3:0]  flags;
   wire        overrunSet;
   wire        syncDone;
   wire        busyNow;

   // ------------------------------------------------------------
   // bus handshakes
   // ------------------------------------------------------------
   assign awTake  = awvalid & awready;
   assign wTake   = wvalid & wready;
   assign wrGo    = awHeld_q & wHeld_q & ~bvalid;
   assign arTake  = arvalid & arready;
   assign arIdx   = araddr[9:2];
   assign wrHit   = wrGo & wLane_q & isMapped(awIdx_q);
   assign wrEvt   = wrHit & (awIdx_q == `ADCEIC_IDX_EVCTL);
   assign wrInSel = wrHit & (awIdx_q == `ADCEIC_IDX_INCTL);
   assign wrClr   = wrHit & (awIdx_q == `ADCEIC_IDX_ENCLR);
   assign wrSet   = wrHit & (awIdx_q == `ADCEIC_IDX_ENSET);
   assign wrFlags = wrHit & (awIdx_q == `ADCEIC_IDX_FLAGS);

   // the result read that clears flags is the address phase of the read
   assign resRead = arTake & (arIdx == `ADCEIC_IDX_RESULT);

   always @* begin
      awHeld_d = awHeld_q;
      wHeld_d  = wHeld_q;
      bvalid_d = bvalid;
      if (awTake) begin
         awHeld_d = 1'b1;
      end
      if (wTake) begin
         wHeld_d = 1'b1;
      end
      if (wrGo) begin
         bvalid_d = 1'b1;
         awHeld_d = 1'b0;
         wHeld_d  = 1'b0;
      end else if (bvalid & bready) begin
         bvalid_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // register read data
   // ------------------------------------------------------------
   always @* begin
      rdata_d  = rdata;
      rresp_d  = rresp;
      rvalid_d = rvalid;
      if (arTake) begin
         rvalid_d = 1'b1;
         rresp_d  = isMapped(arIdx) ? `ADCEIC_RESP_OKAY
                                    : `ADCEIC_RESP_SLVERR;
         rdata_d  = 32'h00000000;
         case (arIdx)
            `ADCEIC_IDX_INCTL:  rdata_d[4:0]  = positiveInputSelect_q;
            `ADCEIC_IDX_EVCTL:  rdata_d[7:0]  = evtCtl_q;
            `ADCEIC_IDX_ENCLR,
            `ADCEIC_IDX_ENSET:  rdata_d[3:0]  = intEn_q;
            `ADCEIC_IDX_FLAGS:  rdata_d[3:0]  = flags;
            `ADCEIC_IDX_STATUS: rdata_d[`ADCEIC_STATUS_BUSY] = busyNow;
            `ADCEIC_IDX_RESULT: rdata_d[15:0] = result_q;
            default:            rdata_d       = 32'h00000000;
         endcase
      end else if (rvalid & rready) begin
         rvalid_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control register updates
   // ------------------------------------------------------------
   always @* begin
      evtCtl_d = evtCtl_q;
      inSel_d  = positiveInputSelect_q;
      intEn_d  = intEn_q;
      if (wrEvt) begin
         evtCtl_d = wData_q & `ADCEIC_EVCTL_MASK;
      end
      if (wrInSel) begin
         inSel_d = wData_q[4:0];
      end
      if (wrClr) begin
         intEn_d = intEn_q & ~wData_q[3:0];
      end
      if (wrSet) begin
         intEn_d = intEn_q | wData_q[3:0];
      end
   end

   // ------------------------------------------------------------
   // flag sources
   // ------------------------------------------------------------
   // a new result while the last is still unread, and not read now
   assign overrunSet = convResultValid & unread_q & ~resRead;

   assign flagSet[`ADCEIC_FL_RES]  = convResultValid;
   assign flagSet[`ADCEIC_FL_OVR]  = overrunSet;
   // the flag register adds the one clock after the match
   assign flagSet[`ADCEIC_FL_WIN]  = windowMatch;
   assign flagSet[`ADCEIC_FL_SYNC] = syncDone;

   assign flagClr = ({4{wrFlags}} & wData_q[3:0])
                  | ({4{resRead}} & `ADCEIC_READ_CLR);

   adceic_flag_bank #(
      .W       (4)
   ) u_flags (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clkEn   (clkEn),
      .setReq  (flagSet),
      .clrReq  (flagClr),
      .flags_q (flags)
   );

   adceic_sync_watch u_sync (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .clkEn       (clkEn),
      .domain_sync_pending    (domain_sync_pending),
      .syncBySetup (syncBySetup),
      .busy_q      (busyNow),
      .done_q      (syncDone)
   );

   // ------------------------------------------------------------
   // bus registers
   // ------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awIdx_q  <= `ADCEIC_RST_8;
         wHeld_q  <= 1'b0;
         wData_q  <= `ADCEIC_RST_8;
         wLane_q  <= 1'b0;
         awready  <= 1'b0;
         wready   <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= `ADCEIC_RESP_OKAY;
         arready  <= 1'b0;
         rvalid   <= 1'b0;
         rdata    <= 32'h00000000;
         rresp    <= `ADCEIC_RESP_OKAY;
      end else if (clkEn) begin
         awHeld_q <= awHeld_d;
         wHeld_q  <= wHeld_d;
         bvalid   <= bvalid_d;
         awready  <= ~awHeld_d & ~bvalid_d;
         wready   <= ~wHeld_d & ~bvalid_d;
         if (awTake) begin
            awIdx_q <= awaddr[9:2];
         end
         if (wTake) begin
            wData_q <= wdata[7:0];
            wLane_q <= wstrb[0];
         end
         if (wrGo) begin
            bresp <= isMapped(awIdx_q) ? `ADCEIC_RESP_OKAY
                                       : `ADCEIC_RESP_SLVERR;
         end
         rvalid  <= rvalid_d;
         rdata   <= rdata_d;
         rresp   <= rresp_d;
         arready <= ~rvalid_d;
      end
   end

   // ------------------------------------------------------------
   // control and result registers
   // ------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         evtCtl_q              <= `ADCEIC_RST_8;
         intEn_q               <= `ADCEIC_RST_4;
         positiveInputSelect_q <= `ADCEIC_RST_IN;
         result_q              <= `ADCEIC_RST_RES;
         unread_q              <= 1'b0;
      end else if (clkEn) begin
         evtCtl_q              <= evtCtl_d;
         intEn_q               <= intEn_d;
         positiveInputSelect_q <= inSel_d;
         if (convResultValid) begin
            result_q <= convResultData;
         end
         unread_q <= convResultValid | (unread_q & ~resRead);
      end
   end

   // ------------------------------------------------------------
   // input routing decode
   // ------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         selBandgap_q     <= 1'b0;
         selCoreQuarter_q <= 1'b0;
         selPadQuarter_q  <= 1'b0;
      end else if (clkEn) begin
         selBandgap_q     <= (inSel_d == `ADCEIC_SEL_BANDGAP);
         selCoreQuarter_q <= (inSel_d == `ADCEIC_SEL_COREQ);
         selPadQuarter_q  <= (inSel_d == `ADCEIC_SEL_PADQ);
      end
   end

   // ------------------------------------------------------------
   // event inputs and outputs, interrupt line
   // ------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         startReq_q     <= 1'b0;
         flushReq_q     <= 1'b0;
         flushPend_q    <= 1'b0;
         resultEvtOut_q <= 1'b0;
         windowEvtOut_q <= 1'b0;
         irq_q          <= 1'b0;
      end else if (clkEn) begin
         // flush first, the restart follows one cycle later
         flushReq_q  <= flushEvtIn & evtCtl_q[`ADCEIC_EV_FLUSH];
         flushPend_q <= flushEvtIn & evtCtl_q[`ADCEIC_EV_FLUSH];
         startReq_q  <= (startEvtIn & evtCtl_q[`ADCEIC_EV_START])
                      | flushPend_q;
         resultEvtOut_q <= convResultValid
                         & evtCtl_q[`ADCEIC_EV_RESOUT];
         windowEvtOut_q <= windowMatch
                         & evtCtl_q[`ADCEIC_EV_WINOUT];
         irq_q <= |(flags & intEn_d);
      end
   end

endmodule // adceic_top
`default_nettype wire

/* testbench/adceic_checker_assertions.sv */
// checker: event and read-channel timing of the event/irq block
`timescale 1ns/1ns
`default_nettype none
`include "adceic_defines.vh"
module adceic_checker (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        clkEn,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic        startEvtIn,
   input wire logic        flushEvtIn,
   input wire logic        windowMatch,
   input wire logic        convResultValid,
   input wire logic        startReq_q,
   input wire logic        flushReq_q,
   input wire logic        resultEvtOut_q,
   input wire logic        windowEvtOut_q,
   input wire logic [4:0]  positiveInputSelect_q,
   input wire logic        selBandgap_q,
   input wire logic        selCoreQuarter_q,
   input wire logic        selPadQuarter_q
);
   // ------
   // assertions
   // ------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_SEL_CODE: assert property ($stable(positiveInputSelect_q)[*2] |->
      {selPadQuarter_q, selCoreQuarter_q, selBandgap_q} ==
      {positiveInputSelect_q == `ADCEIC_SEL_PADQ,
       positiveInputSelect_q == `ADCEIC_SEL_COREQ,
       positiveInputSelect_q == `ADCEIC_SEL_BANDGAP})
      else $error("input select decode wrong");
   AST_WIN_EVT: assert property (windowEvtOut_q |-> $past(windowMatch))
      else $error("window event without match");
   AST_RES_EVT: assert property (resultEvtOut_q |-> $past(convResultValid))
      else $error("result event without result");
   AST_FLUSH_CAUSE: assert property (flushReq_q |-> $past(flushEvtIn))
      else $error("flush without flush event");
   AST_FLUSH_START: assert property (flushReq_q && clkEn |=> startReq_q)
      else $error("no start after flush");
   AST_START_CAUSE: assert property (startReq_q |->
      $past(startEvtIn) || $past(flushReq_q))
      else $error("start without cause");
   AST_RD_ANSWER: assert property (arvalid && arready && clkEn |=> rvalid)
      else $error("read answer late");
   AST_RD_HOLD: assert property (rvalid && !rready && clkEn |=>
      rvalid && $stable(rdata))
      else $error("read data not held");
endmodule // adceic_checker

bind adceic_top adceic_checker u_chk (.clk_sys, .rst, .clkEn, .arvalid,
   .arready, .rvalid, .rready, .rdata, .startEvtIn, .flushEvtIn,
   .windowMatch, .convResultValid, .startReq_q, .flushReq_q,
   .resultEvtOut_q, .windowEvtOut_q, .positiveInputSelect_q,
   .selBandgap_q, .selCoreQuarter_q, .selPadQuarter_q);
`default_nettype wire

/* testbench/adceic_conv_model.sv */
// converter model: answers start requests with results after a delay
`timescale 1ns/1ns
`default_nettype none
module adceic_conv_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        startReq,
   input  wire logic        flushReq,
   input  wire logic [7:0]  dly,
   output var  logic        convResultValid,
   output var  logic [15:0] convResultData
);
   logic        busy_q;
   logic [7:0]  cnt_q;
   logic [15:0] seq_q;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         seq_q <= 16'h0000;
         convResultValid <= 1'b0;
         convResultData <= 16'h0000;
      end else begin
         convResultValid <= 1'b0;
         // data is not held outside a result
         convResultData <= ~convResultData;
         if (flushReq) begin
            busy_q <= 1'b0;
         end else if (startReq) begin
            busy_q <= 1'b1;
            cnt_q <= dly;
         end else if (busy_q && cnt_q <= 8'h01) begin
            busy_q <= 1'b0;
            seq_q <= seq_q + 16'h0111;
            convResultValid <= 1'b1;
            convResultData <= seq_q + 16'h0111;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule // adceic_conv_model
`default_nettype wire

/* testbench/tb_top.sv */
// testbench: register, event and interrupt scenarios
`timescale 1ns/1ns
`default_nettype none
`include "adceic_defines.vh"
module tb_top;
   logic        clk_sys;
   logic        rst = 1'b1, clkEn = 1'b1;
   logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        startEvtIn = 1'b0, flushEvtIn = 1'b0, windowMatch = 1'b0;
   logic        domain_sync_pending = 1'b0, syncBySetup = 1'b0;
   logic [7:0]  dly = 8'h01;
   logic        awready, wready, bvalid, arready, rvalid, irq_q;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        convResultValid, startReq_q, flushReq_q;
   logic [15:0] convResultData;
   logic        resultEvtOut_q, windowEvtOut_q;
   logic        selBandgap_q, selCoreQuarter_q, selPadQuarter_q;
   logic [4:0]  positiveInputSelect_q;
   int          num_errors = 0, tests_run = 0, cycles = 0, resCnt = 0;

   adceic_top DUT (
      .clk_sys, .rst, .clkEn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .startEvtIn, .flushEvtIn,
      .convResultValid, .convResultData, .windowMatch, .domain_sync_pending,
      .syncBySetup, .startReq_q, .flushReq_q, .resultEvtOut_q,
      .windowEvtOut_q, .positiveInputSelect_q, .selBandgap_q,
      .selCoreQuarter_q, .selPadQuarter_q, .irq_q);
   adceic_conv_model partner (
      .clk_sys, .rst, .startReq(startReq_q), .flushReq(flushReq_q), .dly,
      .convResultValid, .convResultData);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (resultEvtOut_q === 1'b1)
         resCnt <= resCnt + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         tally_and_finish();
      end
   end

   // ------
   // tasks
   // ------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run = tests_run + 1;
      if (s !== e) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                     input logic [1:0] er = `ADCEIC_RESP_OKAY);
      logic b;
      b = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b) begin
         @(posedge clk_sys);
         b = bvalid && bready;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         // ready from the first edge until the response is taken
         bready <= !b;
      end
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e,
                     input logic [1:0] er = `ADCEIC_RESP_OKAY);
      logic b;
      b = 1'b0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      while (!b) begin
         @(posedge clk_sys);
         b = rvalid && rready;
         if (arvalid && arready)
            arvalid <= 1'b0;
         // ready one cycle late, so the slave must hold its data
         rready <= !b && !arvalid;
      end
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   // k and e1 are {window, flush, start}; e2 is the start one cycle later
   task automatic pulse(input logic [2:0] k, input logic [2:0] e1,
                        input logic e2);
      startEvtIn <= k[0];
      flushEvtIn <= k[1];
      windowMatch <= k[2];
      @(posedge clk_sys);
      startEvtIn <= 1'b0;
      flushEvtIn <= 1'b0;
      windowMatch <= 1'b0;
      #1;
      chk({29'h0, windowEvtOut_q, flushReq_q, startReq_q}, {29'h0, e1});
      @(posedge clk_sys);
      #1;
      chk({31'h0, startReq_q}, {31'h0, e2});
   endtask

   // ------
   // scenarios
   // ------
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 7; i++)
         rd(8'h14 + i[7:0], 32'h0, (i == 1) ? `ADCEIC_RESP_SLVERR : 2'h0);
      wr(8'h15, 32'hFF, `ADCEIC_RESP_SLVERR);
      for (int i = 0; i < 3; i++) begin
         wr(`ADCEIC_IDX_INCTL, 32'h19 + i);
         chk({27'h0, positiveInputSelect_q}, 32'h19 + i);
         chk({29'h0, selPadQuarter_q, selCoreQuarter_q, selBandgap_q},
             32'h1 << i);
      end
      wr(`ADCEIC_IDX_EVCTL, 32'hFF);
      rd(`ADCEIC_IDX_EVCTL, 32'h33);
      wr(`ADCEIC_IDX_ENSET, 32'h0F);
      rd(`ADCEIC_IDX_ENCLR, 32'h0F);
      wr(`ADCEIC_IDX_ENCLR, 32'h05);
      rd(`ADCEIC_IDX_ENSET, 32'h0A);
      wr(`ADCEIC_IDX_ENSET, 32'h00);
      rd(`ADCEIC_IDX_ENCLR, 32'h0A);
      pulse(3'b001, 3'b001, 1'b0);
      repeat (8) @(posedge clk_sys);
      chk(resCnt, 32'd1);
      rd(`ADCEIC_IDX_FLAGS, 32'h01);
      chk({31'h0, irq_q}, 32'h0);
      wr(`ADCEIC_IDX_ENSET, 32'h01);
      chk({31'h0, irq_q}, 32'h1);
      wr(`ADCEIC_IDX_ENCLR, 32'h01);
      chk({31'h0, irq_q}, 32'h0);
      pulse(3'b001, 3'b001, 1'b0);
      repeat (8) @(posedge clk_sys);
      rd(`ADCEIC_IDX_FLAGS, 32'h03);
      chk({31'h0, irq_q}, 32'h1);
      rd(`ADCEIC_IDX_RESULT, 32'h0222);
      rd(`ADCEIC_IDX_FLAGS, 32'h02);
      wr(`ADCEIC_IDX_FLAGS, 32'h00);
      rd(`ADCEIC_IDX_FLAGS, 32'h02);
      wr(`ADCEIC_IDX_FLAGS, 32'h02);
      rd(`ADCEIC_IDX_FLAGS, 32'h00);
      chk({31'h0, irq_q}, 32'h0);
      pulse(3'b100, 3'b100, 1'b0);
      rd(`ADCEIC_IDX_FLAGS, 32'h04);
      wr(`ADCEIC_IDX_FLAGS, 32'h04);
      rd(`ADCEIC_IDX_FLAGS, 32'h00);
      dly <= 8'd20;
      pulse(3'b010, 3'b010, 1'b1);
      repeat (30) @(posedge clk_sys);
      rd(`ADCEIC_IDX_RESULT, 32'h0333);
      chk(resCnt, 32'd3);
      wr(`ADCEIC_IDX_EVCTL, 32'h00);
      pulse(3'b111, 3'b000, 1'b0);
      wr(`ADCEIC_IDX_FLAGS, 32'h0F);
      wr(`ADCEIC_IDX_EVCTL, 32'h01);
      pulse(3'b001, 3'b001, 1'b0);
      repeat (30) @(posedge clk_sys);
      chk(resCnt, 32'd3);
      rd(`ADCEIC_IDX_FLAGS, 32'h01);
      clkEn <= 1'b0;
      pulse(3'b001, 3'b000, 1'b0);
      clkEn <= 1'b1;
      domain_sync_pending <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(`ADCEIC_IDX_STATUS, 32'h80);
      domain_sync_pending <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(`ADCEIC_IDX_FLAGS, 32'h09);
      chk({31'h0, irq_q}, 32'h1);
      wr(`ADCEIC_IDX_FLAGS, 32'h0F);
      syncBySetup <= 1'b1;
      domain_sync_pending <= 1'b1;
      repeat (3) @(posedge clk_sys);
      domain_sync_pending <= 1'b0;
      repeat (4) @(posedge clk_sys);
      syncBySetup <= 1'b0;
      rd(`ADCEIC_IDX_FLAGS, 32'h00);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rd(`ADCEIC_IDX_EVCTL, 32'h00);
      rd(`ADCEIC_IDX_ENSET, 32'h00);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
